/* File: core/clic_pkg.sv */
// package for the cascaded interrupt controller pair: addresses, fields, types, helpers
package clic_pkg;

	// i/o port decode
	localparam logic [15:0] MASTER_CMD_ADDR = 16'h0020;
	localparam logic [15:0] MASTER_DATA_ADDR = 16'h0021;
	localparam logic [15:0] SLAVE_CMD_ADDR = 16'h00a0;
	localparam logic [15:0] SLAVE_DATA_ADDR = 16'h00a1;

	// command port decode bits
	localparam int INIT_FIRST_BIT = 4;
	localparam int OP_SEL_BIT = 3;

	// op_word_eoi_rotate fields
	localparam int OP2_ROTATE_BIT = 7;
	localparam int OP2_LEVEL_SEL_BIT = 6;
	localparam int OP2_EOI_BIT = 5;

	// op_word_read_poll fields
	localparam int OP3_ESMM_BIT = 6;
	localparam int OP3_SMM_BIT = 5;
	localparam int OP3_POLL_BIT = 2;
	localparam int OP3_RR_BIT = 1;
	localparam int OP3_RIS_BIT = 0;

	// init_word_mode fields
	localparam int MODE_X86_BIT = 0;
	localparam int MODE_AUTO_END_OF_SERVICE_BIT = 1;
	localparam int MODE_SFNM_BIT = 4;

	// bridge_control_register bit that hands line 12 to the mouse logic
	localparam int BRIDGE_MOUSE_BIT = 4;

	// reset values: x86 mode, normal eoi, non-buffered, sfnm off
	localparam logic [7:0] MODE_RESET = 8'h01;
	localparam logic [7:0] MASK_RESET = 8'h00;
	localparam logic [4:0] BASE_RESET = 5'h00;
	localparam logic [7:0] MASTER_CAS_RESET = 8'h04;
	localparam logic [7:0] SLAVE_CAS_RESET = 8'h02;

	// fixed line numbers
	localparam logic [2:0] SPURIOUS_LINE = 3'h7;
	localparam int LINE_TIMER = 0;
	localparam int LINE_CASCADE = 2;
	localparam int LINE_MOUSE = 12;
	localparam int LINE_FPU = 13;

	// lines that may be level triggered; same set is open to pci steering
	localparam logic [15:0] LEVEL_OK_LINES = 16'hdef8;
	localparam logic [15:0] STEER_OK_LINES = LEVEL_OK_LINES;

	typedef enum logic [1:0] {
		INIT_READY = 2'b00,
		INIT_WAIT_VEC = 2'b01,
		INIT_WAIT_CAS = 2'b10,
		INIT_WAIT_MODE = 2'b11
	} clic_init_t;

	typedef struct packed {
		logic [15:0] addr;
		logic wr;
		logic rd;
		logic [7:0] wdata;
	} clic_io_req_t;

	typedef struct packed {
		logic en;
		logic [3:0] line;
	} clic_route_t;

	typedef struct packed {
		logic [15:0] trigger_level;
		logic [7:0] bridge_ctrl;
		clic_route_t [3:0] pci_route;
	} clic_cfg_t;

	// highest priority set bit: {found, index}, index 0 wins
	function automatic logic [3:0] clic_first(input logic [7:0] v);
		logic [3:0] r;
		r = 4'h0;
		for (int i = 7; i >= 0; i--) begin
			if (v[i]) begin
				r = {1'b1, 3'(i)};
			end
		end
		return r;
	endfunction

	function automatic logic [7:0] clic_onehot(input logic [2:0] idx);
		return 8'h01 << idx;
	endfunction

endpackage

/* File: core/clic_top.sv */
// cascaded interrupt controller pair with pci steering and i/o port access
// Function
// RULE_01 - two cascaded controllers, master lines 0-7, slave 8-15, slave feeds master line 2
// RULE_02 - line 13 from fpu error input, line 0 from timer counter 0
// RULE_03 - four active-low pci inputs steerable to lines 3-7, 9-12, 14, 15
// RULE_04 - reset defaults: x86, edge, normal eoi, non-buffered, no special nesting, cascade
// RULE_05 - bridge control bit 4 selects mouse logic for line 12, else pin
// RULE_06 - master command port at 0020h, slave command port at 00a0h
// RULE_07 - command write with bit 4 set is first init word, restarts init
// RULE_08 - next three data port writes store vector, cascade and mode words
// RULE_09 - vector base word gives vector bits 7 to 3, one per controller
// RULE_10 - software sets only bit 2 of master cascade word
// RULE_11 - master broadcasts cascade code; slave drives vector only on id match
// RULE_12 - software writes mode word bit 0 set on both controllers
// RULE_13 - data port write after init loads mask; 1 blocks that line
// RULE_14 - third op word picks read register, special mask mode, poll mode
// RULE_15 - op words accepted anytime after init, no re-init needed
// RULE_16 - non-specific eoi clears highest priority set in-service bit
// RULE_17 - specific eoi clears in-service bit named by level bits
// RULE_18 - in special mask mode non-specific eoi skips masked in-service bits
// RULE_19 - software sends eoi to both master and slave for slave interrupts
// RULE_20 - auto eoi does non-specific eoi at end of last acknowledge pulse
// RULE_21 - software redoes whole init sequence to change mode word
// RULE_22 - software enables auto eoi only on master
// RULE_23 - line 0 highest; in-service blocks equal or lower, higher still interrupts
// RULE_24 - trigger bit 0 edge, 1 level; lines 0,1,2,8,13 always edge
// RULE_25 - master selects slave by driving 010b on cascade lines
// RULE_26 - request gone before first acknowledge gives line 7 vector, no in-service
// RULE_27 - vector is base plus winning line; in-service set on first pulse
`timescale 1ns/10ps
`default_nettype none

module clic_ctrl #(
	parameter bit MASTER = 1'b1
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic [7:0] lines,
	input wire logic [7:0] level_mode,
	input wire logic cmd_wr,
	input wire logic data_wr,
	input wire logic cmd_rd,
	input wire logic [7:0] wdata,
	input wire logic ack_first,
	input wire logic ack_second,
	input wire logic cas_en_in,
	input wire logic [2:0] cas_in,
	output logic cas_en_out,
	output logic [2:0] cas_out,
	output logic int_out,
	output logic owns_vector,
	output logic [7:0] vector,
	output logic [7:0] cmd_rdata,
	output logic [7:0] data_rdata
);
	import clic_pkg::*;

	localparam logic [7:0] CAS_RESET = MASTER ? MASTER_CAS_RESET : SLAVE_CAS_RESET;

	clic_init_t init_ff;
	logic [7:0] line_prev_ff, irr_ff, isr_ff, mask_ff, cas_id_ff, mode_ff;
	logic [4:0] base_ff;
	logic smm_ff, ris_ff, poll_ff, own_ff, part_ff;
	logic [2:0] ack_line_ff;
	logic [3:0] win, top_is;
	logic [7:0] isr_vis, set_is, clr_is, rise, nxt_irr;
	logic pending, selected, take_ack, take, cascade_hit;
	logic is_first, is_op, op2_eoi, op3, eoi_ns;

	// arbitration: masked requests out, in-service masked out only in special mask mode
	// the live line gates the latch so a request dropped at the first pulse reads as spurious
	assign win = clic_first(irr_ff & lines & ~mask_ff); // RULE_26
	assign isr_vis = smm_ff ? (isr_ff & ~mask_ff) : isr_ff;
	assign top_is = clic_first(isr_vis);
	assign pending = win[3] && (!top_is[3] || (win[2:0] < top_is[2:0])); // RULE_23

	// the slave only answers when the master named it on the cascade lines
	assign selected = MASTER ? 1'b1 : (cas_en_in && (cas_in == cas_id_ff[2:0])); // RULE_11
	assign take_ack = ack_first && selected;
	assign take = (take_ack || (cmd_rd && poll_ff)) && pending;
	assign set_is = take ? clic_onehot(win[2:0]) : 8'h00; // RULE_27
	assign cascade_hit = MASTER && take_ack && pending && cas_id_ff[win[2:0]];
	assign cas_en_out = cascade_hit;
	assign cas_out = cascade_hit ? win[2:0] : 3'h0; // RULE_25

	assign is_first = cmd_wr && wdata[INIT_FIRST_BIT]; // RULE_07
	assign is_op = cmd_wr && !wdata[INIT_FIRST_BIT] && (init_ff == INIT_READY); // RULE_15
	assign op2_eoi = is_op && !wdata[OP_SEL_BIT] && wdata[OP2_EOI_BIT] && !wdata[OP2_ROTATE_BIT];
	assign op3 = is_op && wdata[OP_SEL_BIT]; // RULE_14

	// auto eoi runs when the second pulse ends, i.e. at the edge closing that cycle
	assign eoi_ns = (op2_eoi && !wdata[OP2_LEVEL_SEL_BIT])
		|| (ack_second && part_ff && mode_ff[MODE_AUTO_END_OF_SERVICE_BIT]); // RULE_20

	always_comb begin
		clr_is = 8'h00;
		if (op2_eoi && wdata[OP2_LEVEL_SEL_BIT]) begin
			clr_is = clic_onehot(wdata[2:0]); // RULE_17
		end else if (eoi_ns && top_is[3]) begin
			clr_is = clic_onehot(top_is[2:0]); // RULE_16 RULE_18
		end
	end

	// edge lines latch on a rising edge and drop if the line falls before acknowledge
	assign rise = lines & ~line_prev_ff;
	assign nxt_irr = ((level_mode & lines) | (~level_mode & (irr_ff | rise) & lines))
		& ~set_is; // RULE_24 RULE_26

	assign int_out = pending;
	assign owns_vector = own_ff;
	assign vector = {base_ff, ack_line_ff}; // RULE_09 RULE_27
	assign cmd_rdata = poll_ff ? {pending, 4'h0, win[2:0]} : (ris_ff ? isr_ff : irr_ff);
	assign data_rdata = mask_ff;

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			line_prev_ff <= 8'h00;
			irr_ff <= 8'h00;
		end else begin
			line_prev_ff <= lines;
			irr_ff <= nxt_irr;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			isr_ff <= 8'h00;
		end else begin
			isr_ff <= (isr_ff & ~clr_is) | set_is;
		end
	end

	// init sequence: first word on command port, then three data port words in turn
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			init_ff <= INIT_READY;
			base_ff <= BASE_RESET;
			cas_id_ff <= CAS_RESET;
			mode_ff <= MODE_RESET; // RULE_04
		end else if (is_first) begin
			init_ff <= INIT_WAIT_VEC;
		end else if (data_wr) begin
			unique case (init_ff)
				INIT_READY: init_ff <= INIT_READY;
				INIT_WAIT_VEC: begin
					base_ff <= wdata[7:3]; // RULE_08 RULE_09
					init_ff <= INIT_WAIT_CAS;
				end
				INIT_WAIT_CAS: begin
					cas_id_ff <= wdata; // RULE_08
					init_ff <= INIT_WAIT_MODE;
				end
				INIT_WAIT_MODE: begin
					mode_ff <= wdata; // RULE_08
					init_ff <= INIT_READY;
				end
			endcase
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			mask_ff <= MASK_RESET;
		end else if (is_first) begin
			mask_ff <= MASK_RESET;
		end else if (data_wr && (init_ff == INIT_READY)) begin
			mask_ff <= wdata; // RULE_13
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			smm_ff <= 1'b0;
			ris_ff <= 1'b0;
			poll_ff <= 1'b0;
		end else if (is_first) begin
			smm_ff <= 1'b0;
			ris_ff <= 1'b0;
			poll_ff <= 1'b0;
		end else if (op3) begin
			if (wdata[OP3_ESMM_BIT]) begin
				smm_ff <= wdata[OP3_SMM_BIT]; // RULE_14
			end
			if (wdata[OP3_RR_BIT]) begin
				ris_ff <= wdata[OP3_RIS_BIT]; // RULE_14
			end
			poll_ff <= wdata[OP3_POLL_BIT]; // RULE_14
		end else if (cmd_rd) begin
			poll_ff <= 1'b0;
		end
	end

	// acknowledge bookkeeping: line and ownership fixed on the first pulse
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			ack_line_ff <= SPURIOUS_LINE;
			own_ff <= 1'b0;
			part_ff <= 1'b0;
		end else if (take_ack) begin
			ack_line_ff <= pending ? win[2:0] : SPURIOUS_LINE; // RULE_26
			own_ff <= !cascade_hit; // RULE_11
			part_ff <= 1'b1;
		end else if (ack_first) begin
			own_ff <= 1'b0;
			part_ff <= 1'b0;
		end else if (ack_second) begin
			part_ff <= 1'b0;
		end
	end

endmodule

module clic_top (
	input wire logic clk,
	input wire logic rst,
	input wire clic_pkg::clic_io_req_t io_req,
	output logic [7:0] io_rdata,
	output logic io_rvalid,
	input wire clic_pkg::clic_cfg_t cfg,
	input wire logic [15:0] irq_pins,
	input wire logic [3:0] pci_irq_inputs_n,
	input wire logic fpu_error_n,
	input wire logic timer0_out,
	input wire logic mouse_irq,
	input wire logic int_ack_strobe,
	output logic [7:0] ack_vector,
	output logic ack_vector_valid,
	output logic cpu_int_request
);
	import clic_pkg::*;

	logic [15:0] pci_lines, lines, level_mode;
	logic m_cmd, m_data, s_cmd, s_data;
	logic ack_phase_ff, ack_first, ack_second, cas_en;
	logic [2:0] cas_code;
	logic m_int, s_int, m_own, s_own;
	logic [7:0] m_vec, s_vec, m_cmd_rd, m_data_rd, s_cmd_rd, s_data_rd;

	// pci inputs are shared active-low levels; an out-of-set target is ignored
	always_comb begin
		pci_lines = 16'h0000;
		for (int i = 0; i < 4; i++) begin
			if (cfg.pci_route[i].en && !pci_irq_inputs_n[i]) begin
				pci_lines[cfg.pci_route[i].line] = 1'b1;
			end
		end
		pci_lines = pci_lines & STEER_OK_LINES; // RULE_03
	end

	always_comb begin
		lines = irq_pins | pci_lines;
		lines[LINE_TIMER] = timer0_out; // RULE_02
		lines[LINE_CASCADE] = s_int; // RULE_01
		lines[LINE_FPU] = !fpu_error_n; // RULE_02
		if (cfg.bridge_ctrl[BRIDGE_MOUSE_BIT]) begin
			lines[LINE_MOUSE] = mouse_irq; // RULE_05
		end
	end

	assign level_mode = cfg.trigger_level & LEVEL_OK_LINES; // RULE_24

	assign m_cmd = io_req.addr == MASTER_CMD_ADDR; // RULE_06
	assign m_data = io_req.addr == MASTER_DATA_ADDR;
	assign s_cmd = io_req.addr == SLAVE_CMD_ADDR; // RULE_06
	assign s_data = io_req.addr == SLAVE_DATA_ADDR;

	// two strobes make one acknowledge; the phase flag tells them apart
	assign ack_first = int_ack_strobe && !ack_phase_ff;
	assign ack_second = int_ack_strobe && ack_phase_ff;

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			ack_phase_ff <= 1'b0;
		end else if (int_ack_strobe) begin
			ack_phase_ff <= !ack_phase_ff;
		end
	end

	clic_ctrl #(.MASTER(1'b1)) u_master (
		.clk(clk), .rst(rst), .lines(lines[7:0]), .level_mode(level_mode[7:0]),
		.cmd_wr(io_req.wr && m_cmd), .data_wr(io_req.wr && m_data),
		.cmd_rd(io_req.rd && m_cmd), .wdata(io_req.wdata), .ack_first(ack_first),
		.ack_second(ack_second), .cas_en_in(1'b0), .cas_in(3'h0), .cas_en_out(cas_en),
		.cas_out(cas_code), .int_out(m_int), .owns_vector(m_own), .vector(m_vec),
		.cmd_rdata(m_cmd_rd), .data_rdata(m_data_rd));

	clic_ctrl #(.MASTER(1'b0)) u_slave (
		.clk(clk), .rst(rst), .lines(lines[15:8]), .level_mode(level_mode[15:8]),
		.cmd_wr(io_req.wr && s_cmd), .data_wr(io_req.wr && s_data),
		.cmd_rd(io_req.rd && s_cmd), .wdata(io_req.wdata), .ack_first(ack_first),
		.ack_second(ack_second), .cas_en_in(cas_en), .cas_in(cas_code), .cas_en_out(),
		.cas_out(), .int_out(s_int), .owns_vector(s_own), .vector(s_vec),
		.cmd_rdata(s_cmd_rd), .data_rdata(s_data_rd));

	// read data held until the next decoded read; other ports give no answer
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			io_rdata <= 8'h00;
			io_rvalid <= 1'b0;
		end else begin
			io_rvalid <= io_req.rd && (m_cmd || m_data || s_cmd || s_data);
			if (io_req.rd && m_cmd) begin
				io_rdata <= m_cmd_rd;
			end else if (io_req.rd && m_data) begin
				io_rdata <= m_data_rd;
			end else if (io_req.rd && s_cmd) begin
				io_rdata <= s_cmd_rd;
			end else if (io_req.rd && s_data) begin
				io_rdata <= s_data_rd;
			end
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			ack_vector <= 8'h00;
			ack_vector_valid <= 1'b0;
		end else begin
			ack_vector_valid <= ack_second;
			if (ack_second) begin
				ack_vector <= (s_own && !m_own) ? s_vec : m_vec; // RULE_11
			end
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			cpu_int_request <= 1'b0;
		end else begin
			cpu_int_request <= m_int;
		end
	end

endmodule

`default_nettype wire

/* File: test/clic_top_assertions.sv */
// port timing checker for the cascaded interrupt controller pair
`timescale 1ns/10ps
`default_nettype none

module clic_top_assertions
	import clic_pkg::*;
(
	input wire logic clk,
	input wire logic rst,
	input wire clic_pkg::clic_io_req_t io_req,
	input wire logic [7:0] io_rdata,
	input wire logic io_rvalid,
	input wire logic int_ack_strobe,
	input wire logic [7:0] ack_vector,
	input wire logic ack_vector_valid,
	input wire logic cpu_int_request
);
	import clic_pkg::*;
	logic dec;
	logic ph_ff;
	assign dec = io_req.addr == MASTER_CMD_ADDR || io_req.addr == MASTER_DATA_ADDR
		|| io_req.addr == SLAVE_CMD_ADDR || io_req.addr == SLAVE_DATA_ADDR;
	// odd strobes open an acknowledge, even ones close it
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			ph_ff <= 1'b0;
		end else if (int_ack_strobe) begin
			ph_ff <= !ph_ff;
		end
	end
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	property p_rd_ans; io_req.rd && dec |=> io_rvalid; endproperty
	a_rd_ans: assert property (p_rd_ans) else $error("read not answered");
	property p_unmapped; io_req.rd && !dec |=> !io_rvalid; endproperty
	a_unmapped: assert property (p_unmapped) else $error("unmapped read answered");
	property p_rv_cause; io_rvalid |-> $past(io_req.rd) && $past(dec); endproperty
	a_rv_cause: assert property (p_rv_cause) else $error("read valid without read");
	property p_rdata_hold; !io_rvalid |-> $stable(io_rdata); endproperty
	a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved");
	property p_reset; $fell(rst) |-> !io_rvalid && !ack_vector_valid && !cpu_int_request; endproperty
	a_reset: assert property (p_reset) else $error("outputs not cleared by reset");
	property p_vv_second; ack_vector_valid |-> $past(int_ack_strobe) && !ph_ff; endproperty
	a_vv_second: assert property (p_vv_second) else $error("vector not on second pulse");
	property p_vv_pulse; ack_vector_valid |=> !ack_vector_valid; endproperty
	a_vv_pulse: assert property (p_vv_pulse) else $error("vector valid too long");
	property p_vec_hold; !ack_vector_valid |-> $stable(ack_vector); endproperty
	a_vec_hold: assert property (p_vec_hold) else $error("vector moved");
endmodule

bind clic_top clic_top_assertions u_chk (.clk(clk), .rst(rst), .io_req(io_req),
	.io_rdata(io_rdata), .io_rvalid(io_rvalid), .int_ack_strobe(int_ack_strobe),
	.ack_vector(ack_vector), .ack_vector_valid(ack_vector_valid),
	.cpu_int_request(cpu_int_request));

`default_nettype wire

/* File: test/clic_host.sv */
// host processor model: i/o cycles and two-pulse acknowledge
`timescale 1ns/10ps
`default_nettype none

module clic_host
	import clic_pkg::*;
(
	input wire logic clk,
	input wire logic [7:0] io_rdata,
	input wire logic io_rvalid,
	input wire logic [7:0] ack_vector,
	input wire logic ack_vector_valid,
	output var clic_pkg::clic_io_req_t io_req,
	output var logic int_ack_strobe
);
	import clic_pkg::*;
	initial begin
		io_req = '{16'hffff, 1'b0, 1'b0, 8'h00};
		int_ack_strobe = 1'b0;
	end
	// released address and data are inverted so stale values never look valid
	// the answer is taken right after the request edge, then one idle edge passes
	task automatic cyc(input logic [15:0] a, input logic w, input logic [7:0] d,
		output logic [7:0] q, output logic v);
		io_req = '{a, w, !w, d};
		@(posedge clk);
		#1;
		io_req = '{~a, 1'b0, 1'b0, ~d};
		q = io_rdata;
		v = io_rvalid;
		@(posedge clk);
		#1;
	endtask
	task automatic wr(input logic [15:0] a, input logic [7:0] d);
		logic [7:0] q;
		logic v;
		cyc(a, 1'b1, d, q, v);
	endtask
	task automatic rd(input logic [15:0] a, output logic [7:0] d, output logic v);
		cyc(a, 1'b0, 8'h00, d, v);
	endtask
	task automatic init(input logic [15:0] a, input logic [7:0] b, c, m);
		wr(a, 8'h11);
		wr(a + 16'h0001, b);
		wr(a + 16'h0001, c);
		wr(a + 16'h0001, m);
	endtask
	// vector is taken in the cycle right after the second pulse, it stands one cycle
	task automatic ack(output logic [7:0] v, output logic ok);
		int_ack_strobe = 1'b1;
		@(posedge clk);
		#1;
		int_ack_strobe = 1'b0;
		@(posedge clk);
		#1;
		int_ack_strobe = 1'b1;
		@(posedge clk);
		#1;
		int_ack_strobe = 1'b0;
		v = ack_vector;
		ok = ack_vector_valid;
	endtask
endmodule

`default_nettype wire

/* File: test/tb_clic_top.sv */
// testbench for the cascaded interrupt controller pair
`timescale 1ns/10ps
`default_nettype none

`define CHK(a, e) begin num_checks++; if ((a) !== (e)) begin errors++; \
	$display("BAD %0t got %h exp %h", $time, a, e); end end

module tb_clic_top;
	import clic_pkg::*;
	typedef struct packed {logic [2:0] k; logic [3:0] n; logic [7:0] e;} clic_row_t;
	logic clk = 1'b0;
	logic rst = 1'b1;
	clic_io_req_t io_req;
	clic_cfg_t cfg;
	logic [7:0] io_rdata, ack_vector, v;
	logic io_rvalid, ack_vector_valid, cpu_int_request, int_ack_strobe, ok;
	logic [15:0] irq_pins;
	logic [3:0] pci_n;
	logic fpu_n, tmr, mouse;
	int errors = 0;
	int num_checks = 0;
	// kind: 0 pin, 1 timer, 2 fpu, 3 mouse, 4 pci input 0
	clic_row_t rows [8] = '{
		'{3'd1, 4'd0, 8'h08},
		'{3'd0, 4'd1, 8'h09},
		'{3'd0, 4'd3, 8'h0b},
		'{3'd0, 4'd7, 8'h0f},
		'{3'd2, 4'd13, 8'h75},
		'{3'd3, 4'd12, 8'h74},
		'{3'd4, 4'd10, 8'h72},
		'{3'd0, 4'd15, 8'h77}};
	always #5 clk = ~clk;
	clic_top uut (.clk(clk), .rst(rst), .io_req(io_req), .io_rdata(io_rdata),
		.io_rvalid(io_rvalid), .cfg(cfg), .irq_pins(irq_pins), .pci_irq_inputs_n(pci_n),
		.fpu_error_n(fpu_n), .timer0_out(tmr), .mouse_irq(mouse),
		.int_ack_strobe(int_ack_strobe), .ack_vector(ack_vector),
		.ack_vector_valid(ack_vector_valid), .cpu_int_request(cpu_int_request));
	clic_host host (.clk(clk), .io_rdata(io_rdata), .io_rvalid(io_rvalid),
		.ack_vector(ack_vector), .ack_vector_valid(ack_vector_valid), .io_req(io_req),
		.int_ack_strobe(int_ack_strobe));
	task automatic src(input clic_row_t r, input logic on);
		case (r.k)
			3'd0: irq_pins[r.n] = on;
			3'd1: tmr = on;
			3'd2: fpu_n = !on;
			3'd3: mouse = on;
			default: pci_n[0] = !on;
		endcase
	endtask
	// request reaches the cpu line two cycles after a master input moves, three after a slave input
	task automatic w4;
		repeat (4) @(posedge clk);
		#1;
	endtask
	task automatic rd_is(output logic [7:0] d);
		host.wr(MASTER_CMD_ADDR, 8'h0b);
		host.rd(MASTER_CMD_ADDR, d, ok);
	endtask
	task automatic end_of_test;
		$display("checks %0d errors %0d", num_checks, errors);
		if (errors == 0 && num_checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	initial begin
		#200000;
		errors++;
		end_of_test();
	end
	initial begin
		cfg = '0;
		cfg.bridge_ctrl = 8'h10;
		cfg.pci_route[0] = '{1'b1, 4'ha};
		irq_pins = '0;
		pci_n = 4'hf;
		fpu_n = 1'b1;
		tmr = 1'b0;
		mouse = 1'b0;
		repeat (2) @(posedge clk);
		#1;
		rst = 1'b0;
		host.rd(MASTER_DATA_ADDR, v, ok);
		`CHK({ok, v}, 9'h100)
		host.rd(16'h0022, v, ok);
		`CHK(ok, 1'b0)
		host.init(MASTER_CMD_ADDR, 8'h08, 8'h04, 8'h01);
		host.init(SLAVE_CMD_ADDR, 8'h70, 8'h02, 8'h01);
		foreach (rows[i]) begin
			src(rows[i], 1'b1);
			w4();
			`CHK(cpu_int_request, 1'b1)
			host.ack(v, ok);
			`CHK({ok, v}, {1'b1, rows[i].e})
			src(rows[i], 1'b0);
			if (rows[i].e[6])
				host.wr(SLAVE_CMD_ADDR, 8'h20);
			host.wr(MASTER_CMD_ADDR, 8'h20);
		end
		// pin 12 belongs to the mouse logic now, and line 8 is not a steering target
		irq_pins[12] = 1'b1;
		cfg.pci_route[1] = '{1'b1, 4'h8};
		pci_n[1] = 1'b0;
		w4();
		`CHK(cpu_int_request, 1'b0)
		irq_pins[12] = 1'b0;
		pci_n[1] = 1'b1;
		host.wr(MASTER_DATA_ADDR, 8'h08);
		irq_pins[3] = 1'b1;
		w4();
		`CHK(cpu_int_request, 1'b0)
		host.rd(MASTER_DATA_ADDR, v, ok);
		`CHK(v, 8'h08)
		host.wr(MASTER_DATA_ADDR, 8'h00);
		w4();
		`CHK(cpu_int_request, 1'b1)
		host.ack(v, ok);
		`CHK(v, 8'h0b)
		irq_pins[5] = 1'b1;
		w4();
		`CHK(cpu_int_request, 1'b0)
		irq_pins[1] = 1'b1;
		w4();
		`CHK(cpu_int_request, 1'b1)
		host.ack(v, ok);
		`CHK(v, 8'h09)
		rd_is(v);
		`CHK(v, 8'h0a)
		host.wr(MASTER_CMD_ADDR, 8'h20);
		host.rd(MASTER_CMD_ADDR, v, ok);
		`CHK(v, 8'h08)
		host.wr(MASTER_CMD_ADDR, 8'h63);
		w4();
		`CHK(cpu_int_request, 1'b1)
		host.rd(MASTER_CMD_ADDR, v, ok);
		`CHK(v, 8'h00)
		host.ack(v, ok);
		`CHK(v, 8'h0d)
		host.wr(MASTER_CMD_ADDR, 8'h20);
		irq_pins = '0;
		irq_pins[4] = 1'b1;
		w4();
		irq_pins[4] = 1'b0;
		host.ack(v, ok);
		`CHK(v, 8'h0f)
		host.rd(MASTER_CMD_ADDR, v, ok);
		`CHK(v, 8'h00)
		// a masked in-service bit survives a non-specific eoi in special mask mode
		irq_pins[6] = 1'b1;
		w4();
		host.ack(v, ok);
		host.wr(MASTER_CMD_ADDR, 8'h6b);
		host.wr(MASTER_DATA_ADDR, 8'h40);
		host.wr(MASTER_CMD_ADDR, 8'h20);
		host.rd(MASTER_CMD_ADDR, v, ok);
		`CHK(v, 8'h40)
		host.wr(MASTER_CMD_ADDR, 8'h66);
		host.wr(MASTER_CMD_ADDR, 8'h4b);
		host.wr(MASTER_DATA_ADDR, 8'h00);
		irq_pins[6] = 1'b0;
		cfg.trigger_level = 16'h000a;
		irq_pins[1] = 1'b1;
		w4();
		host.ack(v, ok);
		host.wr(MASTER_CMD_ADDR, 8'h20);
		w4();
		`CHK(cpu_int_request, 1'b0)
		irq_pins[1] = 1'b0;
		irq_pins[3] = 1'b1;
		w4();
		host.ack(v, ok);
		host.wr(MASTER_CMD_ADDR, 8'h20);
		w4();
		`CHK(cpu_int_request, 1'b1)
		irq_pins[3] = 1'b0;
		host.ack(v, ok);
		`CHK(v, 8'h0f)
		cfg.trigger_level = '0;
		// abandoned sequence, then a fresh one with auto eoi on the master
		host.wr(MASTER_CMD_ADDR, 8'h11);
		host.wr(MASTER_DATA_ADDR, 8'h50);
		host.init(MASTER_CMD_ADDR, 8'h08, 8'h04, 8'h03);
		irq_pins[3] = 1'b1;
		w4();
		host.ack(v, ok);
		`CHK(v, 8'h0b)
		rd_is(v);
		`CHK(v, 8'h00)
		// poll: the next command port read stands in for the acknowledge
		irq_pins[5] = 1'b1;
		w4();
		host.wr(MASTER_CMD_ADDR, 8'h0c);
		host.rd(MASTER_CMD_ADDR, v, ok);
		`CHK({ok, v}, 9'h185)
		rd_is(v);
		`CHK(v, 8'h20)
		end_of_test();
	end
endmodule

`default_nettype wire
